// >>> bench/osc_source.sv
// Model of the dedicated slow oscillator that feeds the watchdog counter.
// Assumes the bench asks for whole ticks; the pin rests low between them.
`timescale 1ns/1ps
module osc_source (
   input wire logic mclk_in,
   output logic osc_out
);
   // The pin rests low until a tick is asked for.
   initial osc_out = 1'b0;

   // Each tick is one slow period of nine clocks (four high, five low), wide enough for the sync.
   task automatic tick(input int n);
      repeat (n) begin
         @(negedge mclk_in);
         osc_out = 1'b1;
         repeat (4) @(negedge mclk_in);
         osc_out = 1'b0;
         repeat (4) @(negedge mclk_in);
      end
   endtask : tick
endmodule : osc_source

// >>> bench/watchdog_timer_24bit_test.sv
// Self-checking bench for the watchdog: register tasks, ticks, scenarios.
// Assumes the oscillator model in osc_source and the shared package.
`timescale 1ns/1ps
module watchdog_timer_24bit_test;
   logic mclk_in, reset_in, osc_w, refresh_in, always_on_in, resp_in;
   logic stop_in, debug_in, reg_wr_in, reg_rd_in;
   logic [11:0] reg_addr_in;
   logic [7:0] reg_wdata_in, reg_rdata_out, rd_b, stat_exp;
   logic irq_o, sysr_o, rec_o, flag_o, stopf_o, en_o;
   logic [23:0] cnt;
   int fails, check_count, irq_n, sysr_n, rec_n;

   // The device under test with every input driven by the bench.
   watchdog_timer_24bit dut (.mclk_in(mclk_in), .reset_in(reset_in),
      .wdog_osc_in(osc_w), .watchdog_refresh_instruction_in(refresh_in),
      .always_on_option_bit_in(always_on_in),
      .timeout_response_option_bit_in(resp_in), .stop_mode_in(stop_in),
      .debug_mode_in(debug_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .wdog_irq_out(irq_o),
      .sys_reset_out(sysr_o), .stop_recovery_out(rec_o),
      .wdog_flag_out(flag_o), .stop_flag_out(stopf_o),
      .wdog_enabled_out(en_o));

   // The slow oscillator on the far side.
   osc_source osc (.mclk_in(mclk_in), .osc_out(osc_w));

   // A 40 MHz clock.
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end

   // Counts the one-cycle response pulses at the falling edge, where they
   // are settled, so none is missed or counted twice.
   always @(negedge mclk_in) begin
      if (irq_o === 1'b1) irq_n++;
      if (sysr_o === 1'b1) sysr_n++;
      if (rec_o === 1'b1) rec_n++;
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   // Compares one byte.
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk8

   // Compares a whole count.
   task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk24

   // Compares a number of pulses seen.
   task automatic chkn(input int got, input int exp);
      check_count++;
      if (got != exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chkn

   // One register write; the strobe stands for a single cycle.
   task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge mclk_in);
      reg_wr_in = 1'b1;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(negedge mclk_in);
      reg_wr_in = 1'b0;
   endtask : bus_wr

   // One register read; data is settled one edge after the strobe.
   task automatic bus_rd(input logic [11:0] a, output logic [7:0] d);
      @(negedge mclk_in);
      reg_rd_in = 1'b1;
      reg_addr_in = a;
      @(negedge mclk_in);
      reg_rd_in = 1'b0;
      d = reg_rdata_out;
   endtask : bus_rd

   // Reads the live count, upper byte first.
   task automatic rd_count(output logic [23:0] c);
      bus_rd(wdog_pkg::ADDR_RELOAD_UPPER, c[23:16]);
      bus_rd(wdog_pkg::ADDR_RELOAD_HIGH, c[15:8]);
      bus_rd(wdog_pkg::ADDR_RELOAD_LOW, c[7:0]);
   endtask : rd_count

   // Unlocks and writes a reload value in the only accepted order.
   task automatic prog(input logic [23:0] v);
      bus_wr(wdog_pkg::ADDR_UNLOCK_CTRL, wdog_pkg::UNLOCK_CODE_FIRST);
      bus_wr(wdog_pkg::ADDR_UNLOCK_CTRL, wdog_pkg::UNLOCK_CODE_SECOND);
      bus_wr(wdog_pkg::ADDR_RELOAD_UPPER, v[23:16]);
      bus_wr(wdog_pkg::ADDR_RELOAD_HIGH, v[15:8]);
      bus_wr(wdog_pkg::ADDR_RELOAD_LOW, v[7:0]);
   endtask : prog

   // One refresh instruction.
   task automatic refresh;
      @(negedge mclk_in);
      refresh_in = 1'b1;
      @(negedge mclk_in);
      refresh_in = 1'b0;
   endtask : refresh

   // Sets the option bits and the stop and debug levels together.
   task automatic set_mode(input logic ao, input logic rs, input logic st,
      input logic dg);
      always_on_in = ao;
      resp_in = rs;
      stop_in = st;
      debug_in = dg;
   endtask : set_mode

   // Holds reset for two clocks and clears the pulse tallies.
   task automatic do_reset;
      @(negedge mclk_in);
      reset_in = 1'b1;
      irq_n = 0;
      sysr_n = 0;
      rec_n = 0;
      repeat (2) @(negedge mclk_in);
      reset_in = 1'b0;
   endtask : do_reset

   // Cuts a hang short well past the expected run length.
   initial begin
      repeat (20000) @(posedge mclk_in);
      fails++;
      results();
   end

   // Main sequence of scenarios.
   initial begin
      reset_in = 1'b0;
      refresh_in = 1'b0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      set_mode(1'b0, 1'b0, 1'b0, 1'b0);
      reg_addr_in = 12'h000;
      reg_wdata_in = 8'h00;
      fails = 0;
      check_count = 0;
      stat_exp = 8'h00;
      stat_exp[wdog_pkg::STAT_WDOG_BIT] = 1'b1;
      do_reset();
      // Reset values and the status view of the control address.
      rd_count(cnt);
      chk24(cnt, {3{wdog_pkg::RELOAD_BYTE_RESET}});
      bus_rd(wdog_pkg::ADDR_UNLOCK_CTRL, rd_b);
      chk8(rd_b, 8'h00);
      chk8({7'h00, en_o}, 8'h00);
      // A locked write, a full sequence, then a write after relocking.
      bus_wr(wdog_pkg::ADDR_RELOAD_UPPER, 8'h00);
      prog(24'h123456);
      bus_wr(wdog_pkg::ADDR_RELOAD_HIGH, 8'h00);
      refresh();
      chk8({7'h00, en_o}, 8'h01);
      rd_count(cnt);
      chk24(cnt, 24'h123456);
      // A foreign write mid-sequence keeps the upper byte already taken
      // and refuses the high and low bytes that follow.
      bus_wr(wdog_pkg::ADDR_UNLOCK_CTRL, wdog_pkg::UNLOCK_CODE_FIRST);
      bus_wr(wdog_pkg::ADDR_UNLOCK_CTRL, wdog_pkg::UNLOCK_CODE_SECOND);
      bus_wr(wdog_pkg::ADDR_RELOAD_UPPER, 8'h00);
      bus_wr(12'h100, 8'h00);
      bus_wr(wdog_pkg::ADDR_RELOAD_HIGH, 8'h00);
      bus_wr(wdog_pkg::ADDR_RELOAD_LOW, 8'h10);
      bus_wr(wdog_pkg::ADDR_UNLOCK_CTRL, 8'h77);
      bus_rd(wdog_pkg::ADDR_UNLOCK_CTRL, rd_b);
      chk8(rd_b, 8'h00);
      refresh();
      osc.tick(1);
      rd_count(cnt);
      chk24(cnt, 24'h003455);
      // Reload, count down to the floor, and a refresh that is ignored.
      prog(24'h000010);
      refresh();
      rd_count(cnt);
      chk24(cnt, 24'h000010);
      osc.tick(14);
      refresh();
      rd_count(cnt);
      chk24(cnt, wdog_pkg::REFRESH_FLOOR);
      osc.tick(2);
      chkn(irq_n, 1);
      chkn(sysr_n + rec_n, 0);
      rd_count(cnt);
      chk24(cnt, wdog_pkg::COUNT_TIMEOUT);
      bus_rd(wdog_pkg::ADDR_UNLOCK_CTRL, rd_b);
      chk8(rd_b, stat_exp);
      bus_rd(wdog_pkg::ADDR_UNLOCK_CTRL, rd_b);
      chk8(rd_b, 8'h00);
      osc.tick(1);
      rd_count(cnt);
      chk24(cnt, wdog_pkg::COUNT_WRAP);
      // Remaining response and STOP combinations, each from a fresh reset.
      for (int m = 1; m < 4; m++) begin
         do_reset();
         prog(24'h000010);
         set_mode(1'b0, m[0], m[1], 1'b0);
         refresh();
         osc.tick(16);
         stat_exp[wdog_pkg::STAT_STOP_BIT] = m[1];
         chkn(irq_n, m == 2 ? 1 : 0);
         chkn(sysr_n, m == 1 ? 1 : 0);
         chkn(rec_n, m[1] ? 1 : 0);
         bus_rd(wdog_pkg::ADDR_UNLOCK_CTRL, rd_b);
         chk8(rd_b, stat_exp);
      end
      set_mode(1'b0, 1'b0, 1'b0, 1'b0);
      // Debug mode keeps the counter at its reload value.
      do_reset();
      prog(24'h000010);
      refresh();
      set_mode(1'b0, 1'b0, 1'b0, 1'b1);
      osc.tick(20);
      rd_count(cnt);
      chk24(cnt, 24'h000010);
      chkn(irq_n, 0);
      // Always-on starts counting with no refresh at all.
      set_mode(1'b1, 1'b0, 1'b0, 1'b0);
      do_reset();
      @(negedge mclk_in);
      chk8({7'h00, en_o}, 8'h01);
      osc.tick(1);
      rd_count(cnt);
      chk24(cnt, 24'hFFFFFE);
      results();
   end
endmodule : watchdog_timer_24bit_test

// >>> rtl/osc_tick_gen.sv
// Turns the slow watchdog oscillator pin into a one-cycle tick enable.
// Assumes the oscillator is far slower than mclk_in.
`timescale 1ns/1ps
module osc_tick_gen (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic osc_in,
   output logic tick_out
);
   // Two-stage synchroniser; only sync2_r reads sync1_r.
   logic sync1_r;
   logic sync2_r;
   // Previous synchronised level for rising-edge detection.
   logic prev_r;

   // The pin crosses into the mclk domain through two flip-flops.
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= osc_in;
         sync2_r <= sync1_r;
      end
   end

   // A rising edge of the synchronised clock yields one tick.
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         prev_r <= 1'b0;
         tick_out <= 1'b0;
      end else begin
         prev_r <= sync2_r;
         tick_out <= sync2_r & ~prev_r;
      end
   end
endmodule : osc_tick_gen

// >>> rtl/reload_unlock_fsm.sv
// Lock state machine that guards the three reload byte registers.
// Assumes one register write strobe per cycle from the CPU side.
`timescale 1ns/1ps
module reload_unlock_fsm (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic wr_in,
   input wire logic [11:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic accept_upper_out,
   output logic accept_high_out,
   output logic accept_low_out
);
   // Sequence progress.
   typedef enum logic [2:0] {
      LOCKED, GOT_FIRST, WAIT_UPPER, WAIT_HIGH, WAIT_LOW
   } lock_state_t;
   lock_state_t state_r;
   lock_state_t state_nxt;
   logic is_ctrl;
   logic first_code;

   assign is_ctrl = (addr_in == wdog_pkg::ADDR_UNLOCK_CTRL);
   assign first_code = is_ctrl && (wdata_in == wdog_pkg::UNLOCK_CODE_FIRST);

   // Any write off the expected step sends the machine back to locked;
   // a fresh first code still starts a new sequence.
   always_comb begin
      state_nxt = state_r;
      if (wr_in) begin
         state_nxt = first_code ? GOT_FIRST : LOCKED;
         unique case (state_r)
            LOCKED: begin
            end
            GOT_FIRST: begin
               if (is_ctrl && wdata_in == wdog_pkg::UNLOCK_CODE_SECOND) begin
                  state_nxt = WAIT_UPPER;
               end
            end
            WAIT_UPPER: begin
               if (addr_in == wdog_pkg::ADDR_RELOAD_UPPER) begin
                  state_nxt = WAIT_HIGH;
               end
            end
            WAIT_HIGH: begin
               if (addr_in == wdog_pkg::ADDR_RELOAD_HIGH) begin
                  state_nxt = WAIT_LOW;
               end
            end
            WAIT_LOW: begin
               if (addr_in == wdog_pkg::ADDR_RELOAD_LOW) begin
                  state_nxt = LOCKED;
               end
            end
            default: begin
               state_nxt = LOCKED;
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         state_r <= LOCKED;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Accept strobes are combinational so the byte lands on the write edge;
   // while locked no reload write is accepted.
   assign accept_upper_out = wr_in && state_r == WAIT_UPPER &&
      addr_in == wdog_pkg::ADDR_RELOAD_UPPER;
   assign accept_high_out = wr_in && state_r == WAIT_HIGH &&
      addr_in == wdog_pkg::ADDR_RELOAD_HIGH;
   assign accept_low_out = wr_in && state_r == WAIT_LOW &&
      addr_in == wdog_pkg::ADDR_RELOAD_LOW;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   // The first code always starts step two; the second code written in
   // step two opens the upper byte. Idle cycles between them are allowed.
   sequence s_code_first;
      wr_in && is_ctrl && wdata_in == wdog_pkg::UNLOCK_CODE_FIRST;
   endsequence
   sequence s_code_second;
      wr_in && is_ctrl && wdata_in == wdog_pkg::UNLOCK_CODE_SECOND &&
      state_r == GOT_FIRST;
   endsequence
   a_unlock_first: assert property (
      s_code_first |=> state_r == GOT_FIRST)
      else $error("first unlock code did not advance the sequence");
   a_unlock_open: assert property (
      s_code_second |=> state_r == WAIT_UPPER)
      else $error("unlock codes did not open the upper byte");
   a_stray_write: assert property (
      wr_in && state_r == WAIT_HIGH &&
      addr_in != wdog_pkg::ADDR_RELOAD_HIGH && !first_code
      |=> state_r == LOCKED && !accept_low_out)
      else $error("stray write did not relock");
   a_locked_ignore: assert property (
      state_r == LOCKED |-> !accept_upper_out && !accept_high_out &&
      !accept_low_out)
      else $error("reload byte accepted while locked");
endmodule : reload_unlock_fsm

// >>> rtl/watchdog_timer_24bit.sv
// Watchdog timer: 24-bit down-counter on a slow oscillator tick, with
// refresh, time-out response, reset status flags and guarded reload bytes.
// Assumes the CPU register bus, option bits, stop and debug levels are all
// synchronous to mclk_in; only the oscillator pin is asynchronous.
`timescale 1ns/1ps
module watchdog_timer_24bit (
   input wire logic mclk_in,
   input wire logic reset_in,
   input wire logic wdog_osc_in,
   input wire logic watchdog_refresh_instruction_in,
   input wire logic always_on_option_bit_in,
   input wire logic timeout_response_option_bit_in,
   input wire logic stop_mode_in,
   input wire logic debug_mode_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic wdog_irq_out,
   output logic sys_reset_out,
   output logic stop_recovery_out,
   output logic wdog_flag_out,
   output logic stop_flag_out,
   output logic wdog_enabled_out
);
   // Oscillator tick, one mclk cycle per oscillator rising edge.
   logic tick;
   // Reload byte strobes from the lock state machine.
   logic accept_upper;
   logic accept_high;
   logic accept_low;
   // Reload bytes written by software.
   logic [7:0] reload_upper_byte_r;
   logic [7:0] reload_high_byte_r;
   logic [7:0] reload_low_byte_r;
   // Full reload value, upper byte most significant.
   logic [wdog_pkg::COUNT_W-1:0] reload_value;
   // Live down-counter.
   logic [wdog_pkg::COUNT_W-1:0] count_r;
   logic [wdog_pkg::COUNT_W-1:0] count_nxt;
   // Enable, reload, time-out and status-read conditions.
   logic first_enable;
   logic refresh_ok;
   logic reload_now;
   logic timeout;
   logic status_read;

   // Slow oscillator is synchronised and turned into a tick enable.
   osc_tick_gen u_tick (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .osc_in(wdog_osc_in),
      .tick_out(tick)
   );

   // Lock state machine; control writes only move its state.
   reload_unlock_fsm u_lock (
      .mclk_in(mclk_in),
      .reset_in(reset_in),
      .wr_in(reg_wr_in),
      .addr_in(reg_addr_in),
      .wdata_in(reg_wdata_in),
      .accept_upper_out(accept_upper),
      .accept_high_out(accept_high),
      .accept_low_out(accept_low)
   );

   // Reload bytes take software data only when the lock opens them.
   // Control address writes touch nothing here.
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         reload_upper_byte_r <= wdog_pkg::RELOAD_BYTE_RESET;
         reload_high_byte_r <= wdog_pkg::RELOAD_BYTE_RESET;
         reload_low_byte_r <= wdog_pkg::RELOAD_BYTE_RESET;
      end else begin
         if (accept_upper) begin
            reload_upper_byte_r <= reg_wdata_in;
         end
         if (accept_high) begin
            reload_high_byte_r <= reg_wdata_in;
         end
         if (accept_low) begin
            reload_low_byte_r <= reg_wdata_in;
         end
      end
   end

   // Reload value is the three bytes, upper first.
   assign reload_value = {reload_upper_byte_r, reload_high_byte_r,
      reload_low_byte_r};

   // Enabling happens once, by refresh or the always-on option.
   assign first_enable = !wdog_enabled_out &&
      (watchdog_refresh_instruction_in || always_on_option_bit_in);
   // A refresh while running only counts above the floor.
   assign refresh_ok = wdog_enabled_out && watchdog_refresh_instruction_in &&
      (count_r > wdog_pkg::REFRESH_FLOOR);
   // Debug mode reloads every cycle so no time-out can happen.
   assign reload_now = first_enable || refresh_ok ||
      (wdog_enabled_out && debug_mode_in);
   // Time-out when a tick moves the count onto zero.
   assign timeout = wdog_enabled_out && !reload_now && tick &&
      (count_r == wdog_pkg::COUNT_TIMEOUT + 24'h000001);
   // A read of the control address is a read of reset status.
   assign status_read = reg_rd_in &&
      (reg_addr_in == wdog_pkg::ADDR_UNLOCK_CTRL);

   // Enable is sticky: nothing but reset turns the watchdog off.
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         wdog_enabled_out <= 1'b0;
      end else if (first_enable) begin
         wdog_enabled_out <= 1'b1;
      end
   end

   // Next count: reload has priority, else step down on a tick.
   // From zero the step wraps to all ones with no reload.
   always_comb begin
      count_nxt = count_r;
      if (reload_now) begin
         count_nxt = reload_value;
      end else if (wdog_enabled_out && tick) begin
         count_nxt = count_r - 24'h000001;
      end
   end

   // Counter register starts at the reset reload value.
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         count_r <= wdog_pkg::COUNT_WRAP;
      end else begin
         count_r <= count_nxt;
      end
   end

   // Time-out response: interrupt or system reset, and stop recovery
   // when the device sleeps. All three are one-cycle pulses.
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         wdog_irq_out <= 1'b0;
         sys_reset_out <= 1'b0;
         stop_recovery_out <= 1'b0;
      end else begin
         // Interrupt response, in or out of stop mode.
         wdog_irq_out <= timeout &&
            !timeout_response_option_bit_in;
         // Reset response outside stop mode only.
         sys_reset_out <= timeout && timeout_response_option_bit_in &&
            !stop_mode_in;
         // Stop mode always recovers instead of resetting.
         stop_recovery_out <= timeout && stop_mode_in;
      end
   end

   // Status flags: set by time-out, cleared by a status read; a set in
   // the same cycle as the read wins.
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         wdog_flag_out <= 1'b0;
         stop_flag_out <= 1'b0;
      end else begin
         if (timeout) begin
            wdog_flag_out <= 1'b1;
         end else if (status_read) begin
            wdog_flag_out <= 1'b0;
         end
         if (timeout && stop_mode_in) begin
            stop_flag_out <= 1'b1;
         end else if (status_read) begin
            stop_flag_out <= 1'b0;
         end
      end
   end

   // Read data, valid the cycle after the read strobe. Reload addresses
   // return the live count; the control address returns reset status.
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         unique case (reg_addr_in)
            wdog_pkg::ADDR_UNLOCK_CTRL: begin
               reg_rdata_out <= 8'h00;
               reg_rdata_out[wdog_pkg::STAT_WDOG_BIT] <= wdog_flag_out;
               reg_rdata_out[wdog_pkg::STAT_STOP_BIT] <= stop_flag_out;
            end
            wdog_pkg::ADDR_RELOAD_UPPER: begin
               reg_rdata_out <= count_r[23:16];
            end
            wdog_pkg::ADDR_RELOAD_HIGH: begin
               reg_rdata_out <= count_r[15:8];
            end
            wdog_pkg::ADDR_RELOAD_LOW: begin
               reg_rdata_out <= count_r[7:0];
            end
            default: begin
               reg_rdata_out <= 8'h00;
            end
         endcase
      end
   end

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   // A refresh above the floor reloads the counter.
   a_refresh_reload: assert property (
      wdog_enabled_out && watchdog_refresh_instruction_in &&
      count_r > wdog_pkg::REFRESH_FLOOR |=> count_r == $past(reload_value))
      else $error("refresh did not reload the counter");
   // A refresh at or below the floor leaves the count alone.
   a_refresh_floor: assert property (
      wdog_enabled_out && watchdog_refresh_instruction_in && !debug_mode_in
      && count_r <= wdog_pkg::REFRESH_FLOOR && !tick
      |=> count_r == $past(count_r))
      else $error("refresh honoured below the floor");
   // First enable loads the reload value.
   a_first_load: assert property (
      !wdog_enabled_out && always_on_option_bit_in
      |=> wdog_enabled_out && count_r == $past(reload_value))
      else $error("first enable did not load reload value");
   // Debug mode keeps the counter at the reload value.
   a_debug_hold: assert property (
      (wdog_enabled_out && debug_mode_in) [*2]
      |-> count_r == $past(reload_value))
      else $error("debug mode let the counter run");
   // Interrupt time-out: request and flag in the cycle the count hits zero.
   sequence s_last_tick;
      timeout && !timeout_response_option_bit_in;
   endsequence
   a_irq_timeout: assert property (
      s_last_tick |=> wdog_irq_out && wdog_flag_out &&
      count_r == wdog_pkg::COUNT_TIMEOUT)
      else $error("interrupt time-out not signalled");
   // From zero the next tick wraps to all ones.
   a_wrap_down: assert property (
      wdog_enabled_out && !reload_now && tick &&
      count_r == wdog_pkg::COUNT_TIMEOUT |=> count_r == wdog_pkg::COUNT_WRAP)
      else $error("counter did not wrap after time-out");
   // Reset response outside stop raises system reset only.
   a_reset_resp: assert property (
      timeout && timeout_response_option_bit_in && !stop_mode_in
      |=> sys_reset_out && !wdog_irq_out && !stop_recovery_out)
      else $error("reset response wrong");
   // Time-out in stop recovers and sets both flags, never a reset.
   a_stop_recover: assert property (
      timeout && stop_mode_in
      |=> stop_recovery_out && !sys_reset_out && wdog_flag_out &&
      stop_flag_out)
      else $error("stop time-out response wrong");
   // A status read without a new time-out clears the flag.
   a_read_clear: assert property (
      status_read && !timeout |=> !wdog_flag_out ##1 !wdog_irq_out)
      else $error("status read did not clear the flag");
   // Control writes never alter the reload bytes.
   a_ctrl_nochange: assert property (
      reg_wr_in && reg_addr_in == wdog_pkg::ADDR_UNLOCK_CTRL
      |=> reload_value == $past(reload_value))
      else $error("control write changed stored bits");
endmodule : watchdog_timer_24bit

// >>> rtl/wdog_pkg.sv
// Constants shared by the watchdog design files.
// Assumes an 8-bit register space with 12-bit addresses on the CPU side.
package wdog_pkg;
   // Width of the down-counter and of the reload value.
   localparam int COUNT_W = 24;
   // Register space addresses.
   localparam logic [11:0] ADDR_UNLOCK_CTRL = 12'hFF0;
   localparam logic [11:0] ADDR_RELOAD_UPPER = 12'hFF1;
   localparam logic [11:0] ADDR_RELOAD_HIGH = 12'hFF2;
   localparam logic [11:0] ADDR_RELOAD_LOW = 12'hFF3;
   // Unlock codes written to the control address, in order.
   localparam logic [7:0] UNLOCK_CODE_FIRST = 8'h55;
   localparam logic [7:0] UNLOCK_CODE_SECOND = 8'hAA;
   // Reset value of each reload byte.
   localparam logic [7:0] RELOAD_BYTE_RESET = 8'hFF;
   // Count at or below which a refresh is no longer honoured.
   localparam logic [23:0] REFRESH_FLOOR = 24'h000002;
   // Smallest reload value that software may program.
   localparam logic [23:0] RELOAD_MIN = 24'h000004;
   // Count at which the time-out is declared, and the wrapped value.
   localparam logic [23:0] COUNT_TIMEOUT = 24'h000000;
   localparam logic [23:0] COUNT_WRAP = 24'hFFFFFF;
   // Field positions in the reset status byte.
   localparam int STAT_WDOG_BIT = 5;
   localparam int STAT_STOP_BIT = 4;
   // Nominal oscillator rate; time-out in ms is reload divided by ten.
   localparam int OSC_FREQ_HZ = 10000;
   localparam int MS_PER_SECOND = 1000;
   localparam int TICKS_PER_MS = OSC_FREQ_HZ / MS_PER_SECOND;
endpackage : wdog_pkg
